// *** logic/exec_pkg.sv ***
// Shared constants, types and helpers for the bit, shift and load executor
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int REG_CNT = 32;
    localparam int RD_PORTS = 5;
    localparam int WR_PORTS = 3;
    // *************************************************************
    // Status byte bit positions and reset values
    // *************************************************************
    localparam logic [2:0] SB_C = 3'h0;
    localparam logic [2:0] SB_Z = 3'h1;
    localparam logic [2:0] SB_N = 3'h2;
    localparam logic [2:0] SB_V = 3'h3;
    localparam logic [2:0] SB_S = 3'h4;
    localparam logic [2:0] SB_H = 3'h5;
    localparam logic [2:0] SB_T = 3'h6;
    localparam logic [2:0] SB_I = 3'h7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] REG_RESET = 8'h00;
    // *************************************************************
    // Pointer pairs and debug port map
    // *************************************************************
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;
    localparam logic [5:0] DBG_STATUS = 6'h20;
    localparam logic [5:0] DBG_PC_LO = 6'h21;
    localparam logic [5:0] DBG_PC_HI = 6'h22;
    // Cycle counts of the two instruction classes
    localparam int CYC_SINGLE = 1;
    localparam int CYC_DOUBLE = 2;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_SECOND = 2'b01
    } state_t;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_BR_NO_OVF = 5'h01,
        OP_BR_IRQ_ON = 5'h02,
        OP_BR_IRQ_OFF = 5'h03,
        OP_IO_SET = 5'h04,
        OP_IO_CLEAR = 5'h05,
        OP_SHL = 5'h06,
        OP_SHR = 5'h07,
        OP_ROL = 5'h08,
        OP_ROR = 5'h09,
        OP_ASR = 5'h0a,
        OP_SWAP = 5'h0b,
        OP_FLAG_RAISE = 5'h0c,
        OP_FLAG_LOWER = 5'h0d,
        OP_T_STORE = 5'h0e,
        OP_T_LOAD = 5'h0f,
        OP_MOVE = 5'h10,
        OP_PAIR_COPY = 5'h11,
        OP_LOAD_CONST = 5'h12,
        OP_LD_PLAIN = 5'h13,
        OP_LD_POST = 5'h14,
        OP_LD_PRE = 5'h15,
        OP_LD_DISP = 5'h16
    } op_t;

    typedef enum logic [1:0] {
        PTR_X = 2'b00,
        PTR_Y = 2'b01,
        PTR_Z = 2'b10
    } ptr_t;

    typedef struct packed {
        op_t op;
        logic [4:0] dst;
        logic [4:0] src;
        logic [2:0] bit_sel;
        logic [7:0] imm;
        ptr_t ptr;
        logic [5:0] disp;
        logic [6:0] offset;
    } cmd_t;

    typedef struct packed {
        logic [7:0] value;
        logic c;
        logic z;
        logic n;
        logic v;
    } shift_res_t;

    // Register index of the low byte of a pointer pair
    function automatic logic [4:0] ptr_base(ptr_t p);
        unique case (p)
            PTR_Y: ptr_base = PTR_Y_LO;
            PTR_Z: ptr_base = PTR_Z_LO;
            default: ptr_base = PTR_X_LO;
        endcase
    endfunction

    function automatic logic is_load(op_t o);
        is_load = (o == OP_LD_PLAIN) || (o == OP_LD_POST) ||
                  (o == OP_LD_PRE) || (o == OP_LD_DISP);
    endfunction

    function automatic logic is_io(op_t o);
        is_io = (o == OP_IO_SET) || (o == OP_IO_CLEAR);
    endfunction
endpackage

// *** logic/reg_bank.sv ***
// Thirty-two byte working register bank, several read and write ports
`timescale 1ns/1ps
`default_nettype none
module reg_bank
    import exec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [RD_PORTS-1:0][4:0] rd_addr,
    output logic [RD_PORTS-1:0][7:0] rd_data,
    input wire logic [WR_PORTS-1:0] wr_en,
    input wire logic [WR_PORTS-1:0][4:0] wr_addr,
    input wire logic [WR_PORTS-1:0][7:0] wr_data
);
    // One element per register, so each write process owns its own word
    logic [7:0] regs [REG_CNT];

    // Reads stay combinational so single-cycle ops finish in one clock
    for (genvar r = 0; r < RD_PORTS; r++) begin : g_rd
        assign rd_data[r] = regs[rd_addr[r]];
    end

    // Port 0 has the highest priority, so it is applied last
    for (genvar i = 0; i < REG_CNT; i++) begin : g_reg
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                regs[i] <= REG_RESET;
            end else if (ce) begin
                for (int p = WR_PORTS - 1; p >= 0; p--) begin
                    if (wr_en[p] && wr_addr[p] == 5'(i)) begin
                        regs[i] <= wr_data[p];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** logic/shift_unit.sv ***
// Shift, rotate and nibble exchange datapath with its flag results
`timescale 1ns/1ps
`default_nettype none
module shift_unit
    import exec_pkg::*;
(
    input wire op_t op,
    input wire logic [7:0] value,
    input wire logic carry_in,
    output shift_res_t res
);
    always_comb begin
        res.value = value;
        res.c = carry_in;
        unique case (op)
            OP_SHL: begin
                res.value = {value[6:0], 1'b0};
                res.c = value[7];
            end
            OP_SHR: begin
                res.value = {1'b0, value[7:1]};
                res.c = value[0];
            end
            OP_ROL: begin
                res.value = {value[6:0], carry_in};
                res.c = value[7];
            end
            OP_ROR: begin
                res.value = {carry_in, value[7:1]};
                res.c = value[0];
            end
            OP_ASR: begin
                res.value = {value[7], value[7:1]};
                res.c = value[0];
            end
            OP_SWAP: begin
                res.value = {value[3:0], value[7:4]};
            end
            default: begin
                res.value = value;
            end
        endcase
        res.z = (res.value == 8'h00);
        res.n = res.value[7];
        res.v = res.n ^ res.c;
    end
endmodule
`default_nettype wire

// *** logic/exec_core.sv ***
// Executor for branches, bit, shift, flag, move and indirect load ops
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module exec_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire exec_pkg::cmd_t cmd,
    output logic cmd_ready,
    output logic done,
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic io_rd,
    output logic io_wr,
    output logic [4:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic [5:0] dbg_addr,
    input wire logic [7:0] dbg_wdata,
    input wire logic dbg_wr,
    input wire logic dbg_rd,
    output logic [7:0] dbg_rdata
);
    import exec_pkg::*;

    // *************************************************************
    // Architectural state
    // *************************************************************
    state_t state;
    cmd_t held;
    logic [7:0] status;
    logic [15:0] pc;

    logic accept;
    logic taken;
    logic needs_second;
    logic [15:0] branch_target;
    logic [15:0] ptr;
    logic [15:0] next_ptr;
    logic [15:0] load_addr;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] dbg_val;
    logic [4:0] pair_lo;
    shift_res_t shres;

    logic [RD_PORTS-1:0][4:0] rd_addr;
    logic [RD_PORTS-1:0][7:0] rd_data;
    logic [WR_PORTS-1:0] wr_en;
    logic [WR_PORTS-1:0][4:0] wr_addr;
    logic [WR_PORTS-1:0][7:0] wr_data;

    // Debug writes stall issue so they never race a cycle-0 update
    assign cmd_ready = ce && state == S_IDLE && !dbg_wr;
    assign accept = cmd_valid && cmd_ready;

    // *************************************************************
    // Operand fetch
    // *************************************************************
    assign pair_lo = (cmd.op == OP_PAIR_COPY) ? {cmd.src[4:1], 1'b0}
                                              : ptr_base(cmd.ptr);
    assign rd_addr[0] = cmd.dst;
    assign rd_addr[1] = cmd.src;
    assign rd_addr[2] = pair_lo;
    assign rd_addr[3] = {pair_lo[4:1], 1'b1};
    assign rd_addr[4] = dbg_addr[4:0];
    assign rd_val = rd_data[0];
    assign rr_val = rd_data[1];
    assign ptr = {rd_data[3], rd_data[2]};
    assign dbg_val = rd_data[4];

    reg_bank u_bank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    shift_unit u_shift (
        .op(cmd.op),
        .value(rd_val),
        .carry_in(status[SB_C]),
        .res(shres)
    );

    // *************************************************************
    // Branch decision and sequencing
    // *************************************************************
    always_comb begin
        unique case (cmd.op)
            OP_BR_NO_OVF: taken = !status[SB_V];
            OP_BR_IRQ_ON: taken = status[SB_I];
            OP_BR_IRQ_OFF: taken = !status[SB_I];
            default: taken = 1'b0;
        endcase
    end

    // Offset is sign-extended so negative values branch backward
    assign branch_target = pc + 16'h0001 +
                           {{9{cmd.offset[6]}}, cmd.offset};
    assign needs_second = taken || is_io(cmd.op) || is_load(cmd.op);
    assign done = (accept && !needs_second) ||
                  (ce && state == S_SECOND);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            held <= '0;
        end else if (ce) begin
            unique case (state)
                S_IDLE: begin
                    if (accept && needs_second) begin
                        state <= S_SECOND;
                        held <= cmd;
                    end
                end
                S_SECOND: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PC_RESET;
        end else if (ce) begin
            if (accept) begin
                pc <= taken ? branch_target : pc + 16'h0001;
            end else if (dbg_wr && dbg_addr == DBG_PC_LO) begin
                pc[7:0] <= dbg_wdata;
            end else if (dbg_wr && dbg_addr == DBG_PC_HI) begin
                pc[15:8] <= dbg_wdata;
            end
        end
    end

    // *************************************************************
    // Status byte
    // *************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status <= STATUS_RESET;
        end else if (ce) begin
            if (accept) begin
                unique case (cmd.op)
                    OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR: begin
                        status[SB_C] <= shres.c;
                        status[SB_Z] <= shres.z;
                        status[SB_N] <= shres.n;
                        status[SB_V] <= shres.v;
                    end
                    OP_FLAG_RAISE: status[cmd.bit_sel] <= 1'b1;
                    OP_FLAG_LOWER: status[cmd.bit_sel] <= 1'b0;
                    OP_T_STORE: status[SB_T] <= rr_val[cmd.bit_sel];
                    default: status <= status;
                endcase
            end else if (dbg_wr && dbg_addr == DBG_STATUS) begin
                status <= dbg_wdata;
            end
        end
    end

    // *************************************************************
    // Memory and I/O access
    // *************************************************************
    always_comb begin
        next_ptr = ptr;
        load_addr = ptr;
        unique case (cmd.op)
            OP_LD_POST: next_ptr = ptr + 16'h0001;
            OP_LD_PRE: begin
                next_ptr = ptr - 16'h0001;
                load_addr = next_ptr;
            end
            OP_LD_DISP: begin
                // The first pair has no displaced form: disp is ignored
                if (cmd.ptr != PTR_X) begin
                    load_addr = ptr + {10'h000, cmd.disp};
                end
            end
            default: load_addr = ptr;
        endcase
    end

    assign mem_rd = accept && is_load(cmd.op);
    assign mem_addr = load_addr;
    assign io_rd = accept && is_io(cmd.op);
    assign io_wr = ce && state == S_SECOND && is_io(held.op);
    assign io_addr = (state == S_SECOND) ? held.imm[4:0] : cmd.imm[4:0];

    always_comb begin
        io_wdata = io_rdata;
        io_wdata[held.bit_sel] = (held.op == OP_IO_SET);
    end

    // *************************************************************
    // Register write-back
    // *************************************************************
    always_comb begin
        wr_en = '0;
        wr_addr[0] = cmd.dst;
        wr_data[0] = rr_val;
        wr_addr[1] = {pair_lo[4:1], 1'b1};
        wr_data[1] = next_ptr[15:8];
        wr_en[2] = dbg_wr && !dbg_addr[5];
        wr_addr[2] = dbg_addr[4:0];
        wr_data[2] = dbg_wdata;
        if (state == S_SECOND) begin
            if (is_load(held.op)) begin
                wr_en[0] = 1'b1;
                wr_addr[0] = held.dst;
                wr_data[0] = mem_rdata;
            end
        end else if (accept) begin
            unique case (cmd.op)
                OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP: begin
                    wr_en[0] = 1'b1;
                    wr_data[0] = shres.value;
                end
                OP_T_LOAD: begin
                    wr_en[0] = 1'b1;
                    wr_data[0] = rd_val;
                    wr_data[0][cmd.bit_sel] = status[SB_T];
                end
                OP_MOVE: wr_en[0] = 1'b1;
                OP_LOAD_CONST: begin
                    wr_en[0] = 1'b1;
                    wr_data[0] = cmd.imm;
                end
                OP_PAIR_COPY: begin
                    wr_en[1:0] = 2'b11;
                    wr_addr[0] = {cmd.dst[4:1], 1'b0};
                    wr_addr[1] = {cmd.dst[4:1], 1'b1};
                    wr_data[0] = ptr[7:0];
                    wr_data[1] = ptr[15:8];
                end
                OP_LD_POST, OP_LD_PRE: begin
                    wr_en[1:0] = 2'b11;
                    wr_addr[0] = pair_lo;
                    wr_data[0] = next_ptr[7:0];
                end
                default: wr_en[1:0] = 2'b00;
            endcase
        end
    end

    // *************************************************************
    // Debug read port
    // *************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dbg_rdata <= 8'h00;
        end else if (ce) begin
            if (!dbg_rd) begin
                dbg_rdata <= 8'h00;
            end else if (!dbg_addr[5]) begin
                dbg_rdata <= dbg_val;
            end else if (dbg_addr == DBG_STATUS) begin
                dbg_rdata <= status;
            end else if (dbg_addr == DBG_PC_LO) begin
                dbg_rdata <= pc[7:0];
            end else if (dbg_addr == DBG_PC_HI) begin
                dbg_rdata <= pc[15:8];
            end else begin
                dbg_rdata <= 8'h00;
            end
        end
    end

    // *************************************************************
    // Checks
    // *************************************************************
    chk_branch_ovf_taken:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && cmd.op == OP_BR_NO_OVF && !status[SB_V] |=>
        state == S_SECOND && pc == $past(branch_target))
        else $error("overflow branch did not take two cycles");

    chk_branch_irq_skip:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && ((cmd.op == OP_BR_IRQ_ON && !status[SB_I]) ||
        (cmd.op == OP_BR_IRQ_OFF && status[SB_I])) |->
        done ##1 (state == S_IDLE && pc == $past(pc) + 16'h0001))
        else $error("untaken interrupt branch misbehaved");

    chk_io_bit_write:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && is_io(cmd.op) |-> io_rd ##1
        (io_wr && io_addr == $past(cmd.imm[4:0]) &&
        status == $past(status)))
        else $error("I/O bit op not written in second cycle");

    chk_shl_flags:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && cmd.op == OP_SHL |=>
        status[SB_C] == $past(rd_val[7]) &&
        status[SB_Z] == ($past(rd_val[6:0]) == 7'h00) &&
        status[SB_V] == (status[SB_N] ^ status[SB_C]))
        else $error("left shift flags wrong");

    chk_shr_flags:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && cmd.op == OP_SHR |=>
        status[SB_C] == $past(rd_val[0]) && !status[SB_N])
        else $error("right shift flags wrong");

    chk_swap_flags:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && cmd.op == OP_SWAP |=> $stable(status))
        else $error("nibble exchange changed status");

    chk_flag_raise:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && cmd.op == OP_FLAG_RAISE |=>
        status == ($past(status) | (8'h01 << $past(cmd.bit_sel))))
        else $error("selected status bit not raised");

    chk_t_store:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && cmd.op == OP_T_STORE |=>
        status[SB_T] == $past(rr_val[cmd.bit_sel]))
        else $error("T flag not copied from register bit");

    chk_pre_dec_addr:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && cmd.op == OP_LD_PRE |->
        mem_rd && mem_addr == ptr - 16'h0001 ##1 state == S_SECOND)
        else $error("pre-decrement load used wrong address");

    chk_move_flags:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && (cmd.op == OP_MOVE || cmd.op == OP_LOAD_CONST) |->
        done ##1 (state == S_IDLE && $stable(status)))
        else $error("move changed flags or took extra cycle");
endmodule
`default_nettype wire

// *** verif/mem_io_model.sv ***
// Data memory and I/O space that answer the executor's accesses
`timescale 1ns/1ps
`default_nettype none
module mem_io_model (
    input wire logic clk_sys,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [4:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata
);
    logic [7:0] io_mem [32];
    initial begin
        mem_rdata = 8'h00;
        io_rdata = 8'h00;
        for (int i = 0; i < 32; i++) io_mem[i] = 8'(i * 37);
    end
    // Stale data is inverted so a late sample never matches by luck
    always @(posedge clk_sys) begin
        mem_rdata <= mem_rd ? mem_addr[7:0] ^ mem_addr[15:8] : ~mem_rdata;
        io_rdata <= io_rd ? io_mem[io_addr] : ~io_rdata;
        if (io_wr) io_mem[io_addr] <= io_wdata;
    end
endmodule
`default_nettype wire

// *** verif/cpu_bit_shift_load_exec_tb_top.sv ***
// Self-checking bench for the bit, shift and load executor
`timescale 1ns/1ps
`default_nettype none
module cpu_bit_shift_load_exec_tb_top;
    import exec_pkg::*;
    logic clk_sys, rst_n, cmd_valid, cmd_ready, done, mem_rd, io_rd, io_wr;
    logic dbg_wr, dbg_rd, ce;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata, io_wdata, io_rdata, dbg_wdata, dbg_rdata;
    logic [4:0] io_addr;
    logic [5:0] dbg_addr;
    cmd_t cmd;
    int err_count = 0;
    int n_tests = 0;
    int m_reg [32];
    int m_sr;
    exec_core exec_core_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
        .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata));
    mem_io_model mem_io_model_inst (.clk_sys(clk_sys), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .io_rd(io_rd),
        .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic dwr(logic [5:0] a, logic [7:0] d);
        dbg_wr <= 1'b1;
        dbg_addr <= a;
        dbg_wdata <= d;
        @(posedge clk_sys);
        dbg_wr <= 1'b0;
        if (a < 6'h20) m_reg[a] = d;
        else if (a == 6'h20) m_sr = d;
        @(posedge clk_sys);
    endtask
    task automatic drd(logic [5:0] a, output logic [7:0] d);
        dbg_rd <= 1'b1;
        dbg_addr <= a;
        @(posedge clk_sys);
        dbg_rd <= 1'b0;
        @(negedge clk_sys);
        d = dbg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic verify(int d);
        logic [7:0] v;
        drd(d[5:0], v);
        chk("register", v, m_reg[d]);
        drd(6'h20, v);
        chk("status", v, m_sr);
    endtask
    // Every command is followed by debug reads, so valid never toggles twice
    task automatic run(cmd_t c, int cyc);
        int n;
        n = 1;
        cmd_valid <= 1'b1;
        cmd <= c;
        @(negedge clk_sys);
        chk("ready", {15'h0000, cmd_ready}, 16'h0001);
        while (done !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            cmd_valid <= 1'b0;
            n++;
            @(negedge clk_sys);
            chk("ready", {15'h0000, cmd_ready}, 16'h0000);
        end
        chk("cycles", n[15:0], cyc[15:0]);
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        report_and_stop();
    end
    initial begin
        cmd_t c;
        op_t sh [6];
        int d, r, x, cf, p, a, t;
        logic [7:0] v, w;
        sh = '{OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP};
        {rst_n, cmd_valid, dbg_wr, dbg_rd} = '0;
        {cmd, dbg_addr, dbg_wdata} = '0;
        ce = 1'b1;
        void'($urandom(32'h474a));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            d = $urandom_range(25);
            r = $urandom_range(255);
            dwr(6'(d), 8'(r));
            dwr(6'h20, 8'($urandom));
            cf = m_sr & 1;
            c = '0;
            c.op = sh[i % 6];
            c.dst = 5'(d);
            c.src = 5'(d);
            run(c, 1);
            case (c.op)
                OP_SHL: x = r << 1;
                OP_SHR: x = r >> 1;
                OP_ROL: x = r << 1 | cf;
                OP_ROR: x = r >> 1 | cf << 7;
                OP_ASR: x = r >> 1 | r & 128;
                default: x = r << 4 | r >> 4;
            endcase
            cf = c.op inside {OP_SHL, OP_ROL} ? r >> 7 : r & 1;
            x = x & 255;
            m_reg[d] = x;
            if (c.op != OP_SWAP) m_sr = m_sr & 'hf0 | cf | (x == 0) << 1 |
                x >> 7 << 2 | (x >> 7 ^ cf) << 3;
            verify(d);
        end
        $display("shift test done");
        for (int b = 0; b < 16; b++) begin
            c = '0;
            c.op = b < 8 ? OP_FLAG_RAISE : OP_FLAG_LOWER;
            c.bit_sel = 3'(b);
            run(c, 1);
            m_sr = b < 8 ? m_sr | 1 << b : m_sr & ~(1 << b % 8);
            verify(0);
        end
        for (int i = 0; i < 8; i++) begin
            d = $urandom_range(25);
            a = $urandom_range(7);
            c = '0;
            c.op = OP_T_STORE;
            c.dst = 5'(d);
            c.src = 5'(d);
            c.bit_sel = 3'(a);
            run(c, 1);
            m_sr = m_sr & 'hbf | (m_reg[d] >> a & 1) << 6;
            verify(d);
            c.op = OP_T_LOAD;
            c.dst = 5'(i);
            c.src = 5'(i);
            c.bit_sel = 3'(7 - a);
            run(c, 1);
            m_reg[i] = m_reg[i] & ~(1 << 7 - a) | (m_sr >> 6 & 1) << 7 - a;
            verify(i);
        end
        $display("flag test done");
        for (int i = 0; i < 6; i++) begin
            c = '0;
            c.op = i % 3 == 0 ? OP_MOVE : i % 3 == 1 ? OP_LOAD_CONST :
                OP_PAIR_COPY;
            c.imm = 8'($urandom);
            d = 2 * $urandom_range(12);
            r = 2 * $urandom_range(12);
            c.dst = 5'(d);
            c.src = 5'(r);
            run(c, 1);
            m_reg[d] = c.op == OP_LOAD_CONST ? int'(c.imm) : m_reg[r];
            if (c.op == OP_PAIR_COPY) m_reg[d + 1] = m_reg[r + 1];
            verify(d);
            verify(d + 1);
        end
        for (int i = 0; i < 12; i++) begin
            p = $urandom_range(65535);
            a = i < 3 ? 64 : $urandom_range(127);
            dwr(6'h21, 8'(p));
            dwr(6'h22, 8'(p >> 8));
            dwr(6'h20, 8'($urandom));
            c = '0;
            c.op = op_t'(i % 3 + 1);
            c.offset = 7'(a);
            t = c.op == OP_BR_NO_OVF ? !(m_sr >> 3 & 1) :
                c.op == OP_BR_IRQ_ON ? m_sr >> 7 : !(m_sr >> 7);
            run(c, 1 + t);
            p = p + 1 + (t ? a - (a >> 6) * 128 : 0);
            drd(6'h21, v);
            drd(6'h22, w);
            chk("pc", {w, v}, p & 'hffff);
        end
        $display("branch test done");
        for (int i = 0; i < 8; i++) begin
            a = $urandom_range(31);
            r = $urandom_range(7);
            c = '0;
            c.op = i[0] ? OP_IO_CLEAR : OP_IO_SET;
            c.imm = 8'(a);
            c.bit_sel = 3'(r);
            x = mem_io_model_inst.io_mem[a];
            x = i[0] ? x & ~(1 << r) : x | 1 << r;
            run(c, 2);
            verify(0);
            chk("io byte", mem_io_model_inst.io_mem[a], x);
        end
        for (int i = 0; i < 12; i++) begin
            p = $urandom_range(65535);
            r = 26 + 2 * (i % 3);
            dwr(6'(r), 8'(p));
            dwr(6'(r + 1), 8'(p >> 8));
            c = '0;
            c.op = op_t'(19 + i / 3);
            c.ptr = ptr_t'(i % 3);
            c.dst = 5'h05;
            c.disp = 6'($urandom);
            a = c.op == OP_LD_PRE ? p - 1 :
                c.op == OP_LD_DISP && i % 3 != 0 ? p + c.disp : p;
            a = a & 'hffff;
            run(c, 2);
            m_reg[5] = a & 255 ^ a >> 8;
            x = c.op == OP_LD_POST ? p + 1 : c.op == OP_LD_PRE ? a : p;
            m_reg[r] = x & 255;
            m_reg[r + 1] = x >> 8 & 255;
            verify(5);
            verify(r);
            verify(r + 1);
        end
        $display("io and load test done");
        // A debug write while the enable is low must leave status frozen
        r = m_sr;
        ce <= 1'b0;
        dwr(6'h20, 8'(~r));
        ce <= 1'b1;
        m_sr = r;
        verify(0);
        $display("freeze test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
